// [bench/ext_irq_pin_sense_flags_monitor.sv]
// Concurrent checks on the pin sense and request flag front end
module ext_irq_monitor
    import ext_irq_pkg::*;
(
    input wire logic                 core_clk,
    input wire logic                 rst_n,
    input wire logic [ADDR_W-1:0]    addr,
    input wire logic [DATA_W-1:0]    wr_data,
    input wire logic                 wr_en,
    input wire logic                 rd_en,
    input wire logic [DATA_W-1:0]    rd_data,
    input wire logic [PORT_PINS-1:0] port_irq_pin,
    input wire logic [DED_PINS-1:0]  dedicated_req_pin,
    input wire logic [FLAG_W-1:0]    external_request_flags,
    input wire logic                 irq
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [PORT_PINS-1:0] sense_q;
    logic [PORT_PINS-1:0] en_q;
    logic [11:0]          ded_q;
    logic [2:0]           age_q;
    logic [DED_PINS-1:0]  lvl_m;
    logic [DED_PINS-1:0]  edge_m;
    logic [DED_PINS-1:0]  rise_m;
    logic                 cfg_wr;
    ////////////////////////////////////////////////////////////////////////
    // Shadow of the configuration; age gates checks while pipes settle
    assign cfg_wr = wr_en && addr <= DED_SENSE_OFS && addr[1:0] == 2'b00;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sense_q <= SENSE_SEL_RST;
            en_q    <= PIN_EN_RST;
            ded_q   <= DED_SENSE_RST;
        end
        else if (wr_en)
        begin
            if (addr == SENSE_SEL_OFS)
                sense_q <= wr_data[PORT_PINS-1:0];
            if (addr == PIN_EN_OFS)
                en_q <= wr_data[PORT_PINS-1:0];
            if (addr == DED_SENSE_OFS)
                ded_q <= wr_data[11:0];
        end
    end
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            age_q <= 3'h0;
        else if (cfg_wr)
            age_q <= 3'h0;
        else if (age_q != 3'h7)
            age_q <= age_q + 3'h1;
    end
    always_comb
    begin
        for (int n = 0; n < DED_PINS; n++)
        begin
            lvl_m[n]  = ded_q[2*n +: 2] == SENSE_LOW;
            rise_m[n] = ded_q[2*n +: 2] == SENSE_RISE;
            edge_m[n] = rise_m[n] || ded_q[2*n +: 2] == SENSE_FALL;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    chk_reset_clears: assert property (disable iff (1'b0) !rst_n |->
        rd_data == RD_DATA_RST && external_request_flags == REQ_FLAGS_RST)
        else $error("outputs not cleared in reset");
    chk_rd_idle_zero: assert property (!$past(rd_en) |-> rd_data == 0)
        else $error("read data not zero outside read answer");
    chk_cfg_readback: assert property ($past(rd_en) &&
        $past(addr == SENSE_SEL_OFS || addr == PIN_EN_OFS) |->
        rd_data == {16'h0000, $past(addr[2] ? en_q : sense_q)})
        else $error("configuration read back wrong");
    chk_flags_read: assert property ($past(rd_en && addr == REQ_FLAGS_OFS)
        |-> rd_data == {24'h00_0000, $past(external_request_flags)})
        else $error("flag read differs from flag output");
    chk_group_flags: assert property (age_q >= 3 |->
        external_request_flags[7:6] == {|(en_q[7:0] & ~(sense_q[7:0] ^
        $past(port_irq_pin[7:0], 3))), |(en_q[15:8] & ~(sense_q[15:8] ^
        $past(port_irq_pin[15:8], 3)))})
        else $error("group flag not OR of enabled matching pins");
    chk_level_follow: assert property (age_q >= 3 |-> ((lvl_m &
        (external_request_flags[5:0] ^ ~$past(dedicated_req_pin, 3))) == 0))
        else $error("low level flag not following pin");
    chk_edge_set: assert property (age_q >= 5 |-> ((edge_m &
        ~external_request_flags[5:0] & ($past(dedicated_req_pin, 3) ^
        $past(dedicated_req_pin, 4)) & ~($past(dedicated_req_pin, 3) ^
        rise_m)) == 0))
        else $error("pin edge did not set its flag");
    chk_edge_hold: assert property (((edge_m & $past(edge_m) &
        $past(external_request_flags[5:0]) & ~external_request_flags[5:0] &
        ~({6{$past(wr_en && addr == REQ_FLAGS_OFS)}} &
        ~$past(wr_data[5:0]))) == 0))
        else $error("edge flag fell without a zero write");
    cov_irq_rise: cover property ($rose(irq));
    cov_low_group: cover property ($rose(external_request_flags[7]));
    cov_flag_clear: cover property ($fell(external_request_flags[1]));
endmodule
bind ext_irq_pin_sense_flags ext_irq_monitor u_mon (.core_clk(core_clk),
    .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .port_irq_pin(port_irq_pin),
    .dedicated_req_pin(dedicated_req_pin), .irq(irq),
    .external_request_flags(external_request_flags));

// [bench/ext_irq_source.sv]
// Behavioural model of the external sources driving the request pins
module ext_irq_source
    import ext_irq_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    input  wire logic [PORT_PINS-1:0] port_level,
    input  wire logic [DED_PINS-1:0]  ded_level,
    output logic      [PORT_PINS-1:0] port_irq_pin,
    output logic      [DED_PINS-1:0]  dedicated_req_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    ////////////////////////////////////////////////////////////////////////
    // Levels move only after an edge and are held for many cycles, so the
    // synchronisers always see a clean step of two cycles or more
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            port_irq_pin      <= PORT_IDLE;
            dedicated_req_pin <= DED_IDLE;
        end
        else
        begin
            port_irq_pin      <= port_level;
            dedicated_req_pin <= ded_level;
        end
    end
endmodule

// [bench/tb_ext_irq_pin_sense_flags.sv]
// Self-checking bench for the pin sense and request flag front end
module tb_ext_irq_pin_sense_flags
    import ext_irq_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic                 core_clk;
    logic                 rst_n;
    logic [ADDR_W-1:0]    addr;
    logic [DATA_W-1:0]    wr_data;
    logic [DATA_W-1:0]    rd_data;
    logic                 wr_en;
    logic                 rd_en;
    logic                 rd_seen;
    logic                 irq;
    logic [PORT_PINS-1:0] port_level;
    logic [PORT_PINS-1:0] port_irq_pin;
    logic [DED_PINS-1:0]  ded_level;
    logic [DED_PINS-1:0]  dedicated_req_pin;
    logic [FLAG_W-1:0]    flags;
    logic [DATA_W-1:0]    s;
    logic [DATA_W-1:0]    e;
    logic [DATA_W-1:0]    p;
    logic [PORT_PINS-1:0] hit;
    logic [DATA_W-1:0]    exp_q[$];
    int                   error_cnt = 0;
    int                   tests_run = 0;
    localparam logic [ADDR_W-1:0] OFS [7] = '{SENSE_SEL_OFS, PIN_EN_OFS,
        REQ_FLAGS_OFS, DED_SENSE_OFS, EVT_STAT_OFS, EVT_MASK_OFS, 8'h20};
    ////////////////////////////////////////////////////////////////////////
    ext_irq_pin_sense_flags u_dut (.core_clk(core_clk), .rst_n(rst_n),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .port_irq_pin(port_irq_pin), .irq(irq),
        .dedicated_req_pin(dedicated_req_pin),
        .external_request_flags(flags));
    ext_irq_source u_src (.core_clk(core_clk), .rst_n(rst_n),
        .port_level(port_level), .ded_level(ded_level),
        .port_irq_pin(port_irq_pin), .dedicated_req_pin(dedicated_req_pin));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(string nm, logic [DATA_W-1:0] seen,
        logic [DATA_W-1:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic idle(int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        @(posedge core_clk);
        wr_en   <= 1'b1;
        addr    <= a;
        wr_data <= d;
        @(posedge core_clk);
        wr_en   <= 1'b0;
    endtask
    task automatic rd(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] exp);
        @(posedge core_clk);
        rd_en <= 1'b1;
        addr  <= a;
        exp_q.push_back(exp);
        @(posedge core_clk);
        rd_en <= 1'b0;
    endtask
    task automatic regs_zero(string nm);
        for (int i = 0; i < 7; i++)
            rd(OFS[i], 32'h0000_0000);
        idle(3);
        $display("test %s done", nm);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Answer is taken one edge after the strobe edge, oldest note first
    always @(posedge core_clk)
    begin
        rd_seen <= rd_en;
        if (rd_seen === 1'b1)
        begin
            if (exp_q.size() == 0)
                check("unexpected read", 32'h0000_0001, 32'h0000_0000);
            else
                check("rd_data", rd_data, exp_q.pop_front());
        end
    end
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial
    begin
        repeat (20000) @(posedge core_clk);
        check("watchdog", 32'h0000_0001, 32'h0000_0000);
        test_done();
    end
    initial
    begin
        rst_n      = 1'b1;
        addr       = '0;
        wr_data    = '0;
        wr_en      = 1'b0;
        rd_en      = 1'b0;
        port_level = PORT_IDLE;
        ded_level  = DED_IDLE;
        // Late fall gives the asynchronous reset a real edge
        #2 rst_n   = 1'b0;
        void'($urandom(30877));
        idle(10);
        rst_n <= 1'b1;
        regs_zero("reset values");
        s = $urandom();
        e = $urandom();
        wr(SENSE_SEL_OFS, s);
        wr(PIN_EN_OFS, e);
        wr(8'h20, 32'hFFFF_FFFF);
        rd(SENSE_SEL_OFS, s & 32'h0000_FFFF);
        rd(PIN_EN_OFS, e & 32'h0000_FFFF);
        rd(8'h20, 32'h0000_0000);
        $display("test register access done");
        for (int i = 0; i < 8; i++)
        begin
            s = $urandom();
            e = (i == 0) ? 32'h0000_0000 : $urandom();
            p = $urandom();
            wr(SENSE_SEL_OFS, s);
            wr(PIN_EN_OFS, e);
            port_level <= p[15:0];
            idle(6);
            hit = e[15:0] & ~(p[15:0] ^ s[15:0]);
            rd(REQ_FLAGS_OFS, {24'h00_0000, |hit[7:0], |hit[15:8], 6'h00});
        end
        wr(PIN_EN_OFS, 32'h0000_0000);
        port_level <= PORT_IDLE;
        idle(6);
        $display("test group flags done");
        wr(EVT_STAT_OFS, 32'h0000_00FF);
        wr(EVT_MASK_OFS, 32'h0000_0001);
        wr(DED_SENSE_OFS, 32'h0000_00E4);
        idle(6);
        rd(REQ_FLAGS_OFS, 32'h0000_0000);
        // Pin 1 falls in rise mode and pin 3 is reserved: neither may set
        ded_level <= 6'b110000;
        idle(6);
        rd(REQ_FLAGS_OFS, 32'h0000_0005);
        check("irq", irq, 32'h0000_0001);
        ded_level <= DED_IDLE;
        idle(6);
        rd(REQ_FLAGS_OFS, 32'h0000_0003);
        wr(REQ_FLAGS_OFS, 32'h0000_00FD);
        rd(REQ_FLAGS_OFS, 32'h0000_0001);
        wr(REQ_FLAGS_OFS, 32'h0000_0000);
        rd(REQ_FLAGS_OFS, 32'h0000_0000);
        wr(EVT_MASK_OFS, 32'h0000_0000);
        idle(2);
        check("irq masked", irq, 32'h0000_0000);
        wr(EVT_MASK_OFS, 32'h0000_0001);
        idle(2);
        check("irq unmasked", irq, 32'h0000_0001);
        wr(EVT_STAT_OFS, 32'h0000_00FF);
        idle(2);
        check("irq cleared", irq, 32'h0000_0000);
        rd(EVT_STAT_OFS, 32'h0000_0000);
        rd(EVT_MASK_OFS, 32'h0000_0001);
        $display("test dedicated pins done");
        wr(SENSE_SEL_OFS, 32'h0000_FFFF);
        wr(PIN_EN_OFS, 32'h0000_FFFF);
        wr(DED_SENSE_OFS, 32'h0000_0FFF);
        idle(6);
        rst_n <= 1'b0;
        idle(3);
        rst_n <= 1'b1;
        regs_zero("second reset");
        test_done();
    end
endmodule

// [verilog/ext_irq_pin_sense_flags.sv]
// External interrupt pin sense, enable and request flag front end
//
// Function
// - Each port pin has a sense bit: 0 low level, 1 high level.
// - Sense and enable registers reset to zero, kept through standby.
// - Port pin request accepted only while its enable bit is one.
// - Flag bit 7 is read-only, one while pins 0 to 7 request.
// - Flag bit 6 is read-only, one while pins 8 to 15 request.
// - Flag bits 5 to 0 show requests on dedicated pins 5 to 0.
// - Dedicated flags accept only a written zero, which clears them except in low level mode.
// - Edge mode latches the request until software clears the flag.
// - The request flag register resets to zero, kept through standby.
// - Dedicated sense code: 00 fall, 01 rise, 10 low, 11 reserved.
//
// Design decisions made here: strobed register access and the address map.
module ext_irq_pin_sense_flags
    import ext_irq_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    input  wire logic [ADDR_W-1:0]    addr,
    input  wire logic [DATA_W-1:0]    wr_data,
    input  wire logic                 wr_en,
    input  wire logic                 rd_en,
    output logic      [DATA_W-1:0]    rd_data,
    input  wire logic [PORT_PINS-1:0] port_irq_pin,
    input  wire logic [DED_PINS-1:0]  dedicated_req_pin,
    output logic      [FLAG_W-1:0]    external_request_flags,
    output logic                      irq
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [PORT_PINS-1:0]             port_pin_sense_select_q;
    logic [PORT_PINS-1:0]             port_pin_irq_enable_q;
    logic [DED_PINS*SENSE_CODE_W-1:0] ded_sense_q;
    logic [FLAG_W-1:0]                flags_q;
    logic [FLAG_W-1:0]                flags_d;
    logic [FLAG_W-1:0]                evt_stat_q;
    logic [FLAG_W-1:0]                evt_stat_d;
    logic [FLAG_W-1:0]                evt_mask_q;
    logic [DATA_W-1:0]                rd_data_q;
    logic [DATA_W-1:0]                rd_data_d;
    logic                             irq_q;
    logic [PORT_PINS-1:0]             port_pin_s;
    logic [DED_PINS-1:0]              ded_pin_s;
    logic [DED_PINS-1:0]              ded_prev_q;
    logic                             armed_q;
    logic [PORT_PINS-1:0]             port_active;
    logic [DED_PINS-1:0]              ded_hit;
    logic [DED_PINS-1:0]              ded_level;
    logic [DED_PINS-1:0]              ded_flags_d;
    logic                             wr_sense;
    logic                             wr_enable;
    logic                             wr_flags;
    logic                             wr_ded_sense;
    logic                             wr_stat;
    logic                             wr_mask;
    logic [DED_PINS-1:0]              ded_clear;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    pin_sync
    #(
        .WIDTH     (PORT_PINS),
        .RESET_VAL (PORT_IDLE)
    )
    u_port_sync
    (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in (port_irq_pin),
        .sync_out (port_pin_s)
    );

    pin_sync
    #(
        .WIDTH     (DED_PINS),
        .RESET_VAL (DED_IDLE)
    )
    u_ded_sync
    (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in (dedicated_req_pin),
        .sync_out (ded_pin_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // Write decode
    always_comb
    begin
        wr_sense     = wr_en && (addr == SENSE_SEL_OFS);
        wr_enable    = wr_en && (addr == PIN_EN_OFS);
        wr_flags     = wr_en && (addr == REQ_FLAGS_OFS);
        wr_ded_sense = wr_en && (addr == DED_SENSE_OFS);
        wr_stat      = wr_en && (addr == EVT_STAT_OFS);
        wr_mask      = wr_en && (addr == EVT_MASK_OFS);
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers; only reset clears them, standby does not
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            port_pin_sense_select_q <= SENSE_SEL_RST;
        end
        else if (wr_sense)
        begin
            port_pin_sense_select_q <= wr_data[PORT_PINS-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            port_pin_irq_enable_q <= PIN_EN_RST;
        end
        else if (wr_enable)
        begin
            port_pin_irq_enable_q <= wr_data[PORT_PINS-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ded_sense_q <= DED_SENSE_RST;
        end
        else if (wr_ded_sense)
        begin
            ded_sense_q <= wr_data[DED_PINS*SENSE_CODE_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port pin level match and enable gating
    always_comb
    begin
        // Pin requests when its level equals the selected sense bit
        port_active = ~(port_pin_s ^ port_pin_sense_select_q)
                    & port_pin_irq_enable_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // Edge detector priming; avoids a false edge from the reset value
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ded_prev_q <= DED_IDLE;
        end
        else
        begin
            ded_prev_q <= ded_pin_s;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            armed_q <= 1'b0;
        end
        else
        begin
            armed_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Dedicated pin detection per sense code
    always_comb
    begin
        ded_hit   = '0;
        ded_level = '0;
        for (int i = 0; i < DED_PINS; i++)
        begin
            case (ded_sense_type'(ded_sense_q[i*SENSE_CODE_W +:
                                              SENSE_CODE_W]))
                SENSE_FALL:
                begin
                    ded_hit[i] = armed_q && ded_prev_q[i] && !ded_pin_s[i];
                end
                SENSE_RISE:
                begin
                    ded_hit[i] = armed_q && !ded_prev_q[i] && ded_pin_s[i];
                end
                SENSE_LOW:
                begin
                    ded_level[i] = 1'b1;
                end
                // Reserved code detects nothing; flag holds until a written zero clears it
                default:
                begin
                    ded_hit[i] = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request flag next value
    always_comb
    begin
        // Only a written zero clears; a written one is ignored
        ded_clear = wr_flags ? ~wr_data[DED_FLAG_LSB +: DED_PINS]
                             : '0;
        for (int i = 0; i < DED_PINS; i++)
        begin
            if (ded_level[i])
            begin
                // Low level mode follows the pin itself
                ded_flags_d[i] = !ded_pin_s[i];
            end
            else
            begin
                // Edge held until cleared; a new edge beats the clear
                ded_flags_d[i] = ded_hit[i]
                    || (flags_q[DED_FLAG_LSB + i] && !ded_clear[i]);
            end
        end
        flags_d = REQ_FLAGS_RST;
        flags_d[LOW_GROUP_BIT]  = |port_active[GROUP_PINS-1:0];
        flags_d[HIGH_GROUP_BIT] =
            |port_active[PORT_PINS-1:GROUP_PINS];
        flags_d[DED_FLAG_LSB +: DED_PINS] = ded_flags_d;
    end

    // Group bits are status only, writes never reach them
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flags_q <= REQ_FLAGS_RST;
        end
        else
        begin
            flags_q <= flags_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event status, mask and interrupt line
    always_comb
    begin
        // Rising flag sets a sticky bit; set wins over write-one clear
        evt_stat_d = evt_stat_q;
        if (wr_stat)
        begin
            evt_stat_d = evt_stat_q & ~wr_data[FLAG_W-1:0];
        end
        evt_stat_d = evt_stat_d | (flags_d & ~flags_q);
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            evt_stat_q <= EVT_STAT_RST;
        end
        else
        begin
            evt_stat_q <= evt_stat_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            evt_mask_q <= EVT_MASK_RST;
        end
        else if (wr_mask)
        begin
            evt_mask_q <= wr_data[FLAG_W-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= |(evt_stat_d & evt_mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path; data valid the cycle after the strobe, zero otherwise
    always_comb
    begin
        rd_data_d = RD_DATA_RST;
        if (rd_en)
        begin
            case (addr)
                SENSE_SEL_OFS:
                begin
                    rd_data_d[PORT_PINS-1:0] = port_pin_sense_select_q;
                end
                PIN_EN_OFS:
                begin
                    rd_data_d[PORT_PINS-1:0] = port_pin_irq_enable_q;
                end
                REQ_FLAGS_OFS:
                begin
                    rd_data_d[FLAG_W-1:0] = flags_q;
                end
                DED_SENSE_OFS:
                begin
                    rd_data_d[DED_PINS*SENSE_CODE_W-1:0] = ded_sense_q;
                end
                EVT_STAT_OFS:
                begin
                    rd_data_d[FLAG_W-1:0] = evt_stat_q;
                end
                EVT_MASK_OFS:
                begin
                    rd_data_d[FLAG_W-1:0] = evt_mask_q;
                end
                default:
                begin
                    rd_data_d = RD_DATA_RST;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data_q <= RD_DATA_RST;
        end
        else
        begin
            rd_data_q <= rd_data_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign rd_data                = rd_data_q;
    assign external_request_flags = flags_q;
    assign irq                    = irq_q;

endmodule

// [verilog/ext_irq_pkg.sv]
// Constants, register map and types for the external pin interrupt front end
package ext_irq_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int ADDR_W        = 8;
    localparam int DATA_W        = 32;
    localparam int PORT_PINS     = 16;
    localparam int GROUP_PINS    = 8;
    localparam int DED_PINS      = 6;
    localparam int SENSE_CODE_W  = 2;
    localparam int FLAG_W        = 8;
    localparam int SYNC_STAGES   = 2;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [ADDR_W-1:0] SENSE_SEL_OFS  = 8'h00;
    localparam logic [ADDR_W-1:0] PIN_EN_OFS     = 8'h04;
    localparam logic [ADDR_W-1:0] REQ_FLAGS_OFS  = 8'h08;
    localparam logic [ADDR_W-1:0] DED_SENSE_OFS  = 8'h0C;
    localparam logic [ADDR_W-1:0] EVT_STAT_OFS   = 8'h10;
    localparam logic [ADDR_W-1:0] EVT_MASK_OFS   = 8'h14;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [PORT_PINS-1:0]  SENSE_SEL_RST = 16'h0000;
    localparam logic [PORT_PINS-1:0]  PIN_EN_RST    = 16'h0000;
    localparam logic [FLAG_W-1:0]     REQ_FLAGS_RST = 8'h00;
    localparam logic [DED_PINS*SENSE_CODE_W-1:0] DED_SENSE_RST = 12'h000;
    localparam logic [FLAG_W-1:0]     EVT_STAT_RST  = 8'h00;
    localparam logic [FLAG_W-1:0]     EVT_MASK_RST  = 8'h00;
    localparam logic [DATA_W-1:0]     RD_DATA_RST   = 32'h0000_0000;
    localparam logic [DED_PINS-1:0]   DED_IDLE      = 6'h3F;
    localparam logic [PORT_PINS-1:0]  PORT_IDLE     = 16'hFFFF;

    ////////////////////////////////////////////////////////////////////////
    // Field positions in the request flag register
    localparam int LOW_GROUP_BIT  = 7;
    localparam int HIGH_GROUP_BIT = 6;
    localparam int DED_FLAG_LSB   = 0;

    ////////////////////////////////////////////////////////////////////////
    // Sense codes of a dedicated request pin
    typedef enum logic [1:0]
    {
        SENSE_FALL = 2'b00,
        SENSE_RISE = 2'b01,
        SENSE_LOW  = 2'b10,
        SENSE_RSVD = 2'b11
    } ded_sense_type;

endpackage

// [verilog/pin_sync.sv]
// Two flip-flop synchroniser for a bundle of pin inputs
module pin_sync
    import ext_irq_pkg::*;
#(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1_q <= RESET_VAL;
            stage2_q <= RESET_VAL;
        end
        else
        begin
            stage1_q <= async_in;
            stage2_q <= stage1_q;
        end
    end

    assign sync_out = stage2_q;

endmodule
